// file: hw/mcu_memory_map_decoder.sv
// program and data space decoder with reset entry, call and interrupt vectors,
// external pin interrupts and output port secondary function muxing
// assumes core requests are synchronous to clk_sys_i; pins are asynchronous
// Operation
// - program space is byte wide, valid up to 2047 small or 4095 large.
// - after reset the program counter is loaded with address zero.
// - short calls vector into 010H..01FH, eight entries at most.
// - interrupts vector into 020H..02FH.
// - data space is a separate nibble-wide space from program space.
// - data banks hold 256 nibbles; bank 0 system, bank 7 RAM with stack.
// - the stack starts at 7FFH and grows down, 64 or 128 nibbles deep.
// - bank 0 addresses 000H..07FH select the special register area.
// - bank 0 nonvolatile storage runs from 080H to 0BFH or 0FFH.
// - each pin interrupt has its own enable bit.
// - output port bits carry pwm, serial rx, serial tx and serial clock.
// - reset low initialises state, release starts execution at zero.
`timescale 1ns/100ps
module mcu_memory_map_decoder
   import mmap_pkg::*;
#(
   parameter bit LARGE = 1'b0
) (
   // clock and reset
   input  wire logic                 clk_sys_i,
   input  wire logic                 reset_n_i,
   // program side from the core
   input  wire logic                 prog_req_i,
   input  wire logic [PROG_AW-1:0]   prog_addr_i,
   input  wire logic                 scall_req_i,
   input  wire logic [VEC_IDX_W-1:0] scall_idx_i,
   input  wire logic                 irq_ack_i,
   input  wire logic [VEC_IDX_W-1:0] irq_src_i,
   // data side from the core
   input  wire data_req_t            data_req_i,
   // external interrupts
   input  wire logic [PORT_W-1:0]    input_port_i,
   input  wire logic [PORT_W-1:0]    irq_en_i,
   // output port
   input  wire logic [PORT_W-1:0]    port_data_i,
   input  wire logic [PORT_W-1:0]    port_dir_i,
   input  wire logic [PORT_W-1:0]    sec_en_i,
   input  wire sec_out_t             sec_i,
   input  wire logic [PORT_W-1:0]    output_port_pin_i,
   // program results
   output logic                      pc_load_o,
   output logic [PROG_AW-1:0]        pc_target_o,
   output logic                      prog_sel_o,
   output logic                      prog_err_o,
   output logic                      prog_scall_o,
   output logic                      prog_ivec_o,
   // data results
   output data_sel_t                 data_sel_o,
   output logic                      data_none_o,
   output logic                      stack_sel_o,
   // interrupt and port results
   output logic [PORT_W-1:0]         ext_irq_o,
   output logic [PORT_W-1:0]         output_port_o,
   output logic [PORT_W-1:0]         output_port_oe_o,
   output logic                      serial_rx_pin_o,
   output logic                      sclk_in_o
);
   localparam logic [PROG_AW-1:0] PROG_LAST  = LARGE ? PROG_LAST_LARGE : PROG_LAST_SMALL;
   localparam logic [DATA_AW-1:0] NVM_LAST   = LARGE ? NVM_LAST_LARGE : NVM_LAST_SMALL;
   localparam logic [DATA_AW-1:0] RAM_FIRST  = LARGE ? RAM_FIRST_LARGE : RAM_FIRST_SMALL;

   typedef struct packed {
      logic                booted;
      logic                pc_load;
      logic [PROG_AW-1:0]  pc_target;
      logic                prog_sel;
      logic                prog_err;
      logic                scall;
      logic                ivec;
      data_sel_t           dsel;
      logic                dnone;
      logic                stack;
      logic [PORT_W-1:0]   irq;
      logic [PORT_W-1:0]   port;
      logic [PORT_W-1:0]   port_oe;
      logic                rx;
      logic                sclk_in;
   } dec_state_t;

   dec_state_t st_ff;
   dec_state_t nxt_st;

   logic [PORT_W-1:0] in_sync;
   logic [PORT_W-1:0] in_irq;
   logic [PORT_W-1:0] out_sync;

   // each vector slot is two bytes, so eight slots fill sixteen bytes
   function automatic logic [PROG_AW-1:0] vec_addr(input logic [PROG_AW-1:0] base,
                                                   input logic [VEC_IDX_W-1:0] idx);
      vec_addr = base + {{(PROG_AW-VEC_IDX_W-1){1'b0}}, idx, 1'b0};
   endfunction : vec_addr

   function automatic logic in_range(input logic [PROG_AW-1:0] a,
                                     input logic [PROG_AW-1:0] lo,
                                     input logic [PROG_AW-1:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   ext_irq_detect #(
      .W          (PORT_W)
   ) u_in_port (
      .clk_sys_i  (clk_sys_i),
      .reset_n_i  (reset_n_i),
      .pin_i      (input_port_i),
      .irq_en_i   (irq_en_i),
      .pin_sync_o (in_sync),
      .irq_o      (in_irq)
   );

   // output port pins need the same two-stage sync; irq enables held off
   ext_irq_detect #(
      .W          (PORT_W)
   ) u_out_port (
      .clk_sys_i  (clk_sys_i),
      .reset_n_i  (reset_n_i),
      .pin_i      (output_port_pin_i),
      .irq_en_i   ('0),
      .pin_sync_o (out_sync),
      .irq_o      ()
   );

   always_comb begin
      nxt_st         = st_ff;
      // pc redirect: boot entry wins over interrupt, interrupt over short call
      nxt_st.booted  = 1'b1;
      nxt_st.pc_load = 1'b0;
      if (!st_ff.booted) begin
         nxt_st.pc_load   = 1'b1;
         nxt_st.pc_target = RESET_ENTRY;
      end else if (irq_ack_i) begin
         nxt_st.pc_load   = 1'b1;
         nxt_st.pc_target = vec_addr(IVEC_FIRST, irq_src_i);
      end else if (scall_req_i) begin
         nxt_st.pc_load   = 1'b1;
         nxt_st.pc_target = vec_addr(SCALL_FIRST, scall_idx_i);
      end
      // program space decode
      nxt_st.prog_sel = prog_req_i && (prog_addr_i <= PROG_LAST);
      nxt_st.prog_err = prog_req_i && (prog_addr_i > PROG_LAST);
      nxt_st.scall    = prog_req_i && in_range(prog_addr_i, SCALL_FIRST, SCALL_LAST);
      nxt_st.ivec     = prog_req_i && in_range(prog_addr_i, IVEC_FIRST, IVEC_LAST);
      // data space decode, independent of the program side
      nxt_st.dsel  = '0;
      nxt_st.stack = 1'b0;
      if (data_req_i.req) begin
         if (data_req_i.bank == BANK_SYS) begin
            nxt_st.dsel.special_register_area = data_req_i.addr <= SFR_LAST;
            nxt_st.dsel.nvm = (data_req_i.addr >= NVM_FIRST) &&
                              (data_req_i.addr <= NVM_LAST);
         end else if (data_req_i.bank == BANK_RAM) begin
            // stack shares the populated ram window that ends at the top
            nxt_st.dsel.ram = (data_req_i.addr >= RAM_FIRST) &&
                              (data_req_i.addr <= STACK_TOP);
            nxt_st.stack    = nxt_st.dsel.ram;
         end
      end
      nxt_st.dnone = data_req_i.req && (nxt_st.dsel == '0);
      // pin interrupts
      nxt_st.irq = in_irq;
      // output port with secondary functions
      nxt_st.port    = port_data_i;
      nxt_st.port_oe = port_dir_i;
      if (sec_en_i[BIT_PWM]) begin
         nxt_st.port[BIT_PWM]    = sec_i.pwm;
         nxt_st.port_oe[BIT_PWM] = 1'b1;
      end
      if (sec_en_i[BIT_RX]) begin
         nxt_st.port[BIT_RX]    = 1'b0;
         nxt_st.port_oe[BIT_RX] = 1'b0;
      end
      if (sec_en_i[BIT_TX]) begin
         nxt_st.port[BIT_TX]    = sec_i.tx;
         nxt_st.port_oe[BIT_TX] = 1'b1;
      end
      if (sec_en_i[BIT_SCLK]) begin
         nxt_st.port[BIT_SCLK]    = sec_i.sclk_out;
         nxt_st.port_oe[BIT_SCLK] = sec_i.sclk_oe;
      end
      nxt_st.rx      = out_sync[BIT_RX];
      nxt_st.sclk_in = out_sync[BIT_SCLK];
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pc_load_o        = st_ff.pc_load;
   assign pc_target_o      = st_ff.pc_target;
   assign prog_sel_o       = st_ff.prog_sel;
   assign prog_err_o       = st_ff.prog_err;
   assign prog_scall_o     = st_ff.scall;
   assign prog_ivec_o      = st_ff.ivec;
   assign data_sel_o       = st_ff.dsel;
   assign data_none_o      = st_ff.dnone;
   assign stack_sel_o      = st_ff.stack;
   assign ext_irq_o        = st_ff.irq;
   assign output_port_o    = st_ff.port;
   assign output_port_oe_o = st_ff.port_oe;
   assign serial_rx_pin_o  = st_ff.rx;
   assign sclk_in_o        = st_ff.sclk_in;

   property p_boot_zero;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      // the boot load lands at the same edge that sets booted
      $rose(st_ff.booted) |-> (pc_load_o && pc_target_o == RESET_ENTRY);
   endproperty
   a_boot_zero: assert property (p_boot_zero)
      else $error("first pc load after reset is not address zero");

   property p_prog_limit;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      prog_req_i |=> (prog_sel_o == ($past(prog_addr_i) <= PROG_LAST)) &&
         (prog_sel_o != prog_err_o);
   endproperty
   a_prog_limit: assert property (p_prog_limit)
      else $error("program address decoded against the wrong limit");

   property p_scall_vec;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_ff.booted && !irq_ack_i && scall_req_i) |=>
         pc_load_o && pc_target_o == SCALL_FIRST + 12'(2 * $past(scall_idx_i));
   endproperty
   a_scall_vec: assert property (p_scall_vec)
      else $error("short call vector outside its slot");

   property p_irq_vec;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (st_ff.booted && irq_ack_i) |=> pc_load_o &&
         pc_target_o >= IVEC_FIRST && pc_target_o <= IVEC_LAST;
   endproperty
   a_irq_vec: assert property (p_irq_vec)
      else $error("interrupt vector outside its range");

   property p_sfr_sel;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (data_req_i.req && data_req_i.bank == BANK_SYS && data_req_i.addr <= SFR_LAST)
         |=> data_sel_o == 3'b100;
   endproperty
   a_sfr_sel: assert property (p_sfr_sel)
      else $error("special register access not selected");

   property p_nvm_sel;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      data_sel_o.nvm |-> $past(data_req_i.bank) == BANK_SYS &&
         $past(data_req_i.addr) >= NVM_FIRST && $past(data_req_i.addr) <= NVM_LAST;
   endproperty
   a_nvm_sel: assert property (p_nvm_sel)
      else $error("nonvolatile select outside its window");

   property p_one_sel;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      $past(data_req_i.req) |-> $onehot({data_sel_o, data_none_o});
   endproperty
   a_one_sel: assert property (p_one_sel)
      else $error("data access did not yield exactly one outcome");

   property p_stack_top;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (data_req_i.req && data_req_i.bank == BANK_RAM && data_req_i.addr == STACK_TOP)
         |=> stack_sel_o && data_sel_o.ram;
   endproperty
   a_stack_top: assert property (p_stack_top)
      else $error("stack top not in the ram window");

   property p_pwm_out;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      sec_en_i[BIT_PWM] |=> output_port_oe_o[BIT_PWM] &&
         output_port_o[BIT_PWM] == $past(sec_i.pwm);
   endproperty
   a_pwm_out: assert property (p_pwm_out)
      else $error("pwm not driven on port bit 0");
endmodule : mcu_memory_map_decoder

// file: hw/mmap_pkg.sv
// package for the program and data space decoder of a 4-bit controller
// assumes one core clock; widths below are shared by decoder and pin logic
package mmap_pkg;
   localparam int PROG_AW    = 12;
   localparam int DATA_AW    = 8;
   localparam int BANK_W     = 3;
   localparam int PORT_W     = 4;
   localparam int VEC_IDX_W  = 3;
   // program space
   localparam logic [PROG_AW-1:0] PROG_LAST_SMALL = 12'h7ff;
   localparam logic [PROG_AW-1:0] PROG_LAST_LARGE = 12'hfff;
   localparam logic [PROG_AW-1:0] RESET_ENTRY     = 12'h000;
   localparam logic [PROG_AW-1:0] SCALL_FIRST     = 12'h010;
   localparam logic [PROG_AW-1:0] SCALL_LAST      = 12'h01f;
   localparam logic [PROG_AW-1:0] IVEC_FIRST      = 12'h020;
   localparam logic [PROG_AW-1:0] IVEC_LAST       = 12'h02f;
   // data space
   localparam logic [BANK_W-1:0]  BANK_SYS        = 3'h0;
   localparam logic [BANK_W-1:0]  BANK_RAM        = 3'h7;
   localparam logic [DATA_AW-1:0] SFR_LAST        = 8'h7f;
   localparam logic [DATA_AW-1:0] NVM_FIRST       = 8'h80;
   localparam logic [DATA_AW-1:0] NVM_LAST_SMALL  = 8'hbf;
   localparam logic [DATA_AW-1:0] NVM_LAST_LARGE  = 8'hff;
   localparam logic [DATA_AW-1:0] STACK_TOP       = 8'hff;
   localparam logic [DATA_AW-1:0] RAM_FIRST_SMALL = 8'hc0;
   localparam logic [DATA_AW-1:0] RAM_FIRST_LARGE = 8'h80;
   // output port bit roles for secondary functions
   localparam int BIT_PWM  = 0;
   localparam int BIT_RX   = 1;
   localparam int BIT_TX   = 2;
   localparam int BIT_SCLK = 3;

   typedef struct packed {
      logic special_register_area;
      logic nvm;
      logic ram;
   } data_sel_t;

   typedef struct packed {
      logic                  req;
      logic [BANK_W-1:0]     bank;
      logic [DATA_AW-1:0]    addr;
   } data_req_t;

   typedef struct packed {
      logic pwm;
      logic tx;
      logic sclk_out;
      logic sclk_oe;
   } sec_out_t;
endpackage : mmap_pkg

// file: hw/ext_irq_detect.sv
// input port synchroniser and level-change interrupt detector
// assumes pins are asynchronous to clk_sys_i; enable bits come from core logic
`timescale 1ns/100ps
module ext_irq_detect
   import mmap_pkg::*;
#(
   parameter int W = PORT_W
) (
   // clock and reset
   input  wire logic         clk_sys_i,
   input  wire logic         reset_n_i,
   // pins and enables
   input  wire logic [W-1:0] pin_i,
   input  wire logic [W-1:0] irq_en_i,
   // results
   output logic      [W-1:0] pin_sync_o,
   output logic      [W-1:0] irq_o
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] last;
      logic [W-1:0] irq;
   } det_state_t;

   det_state_t st_ff;
   det_state_t nxt_st;

   always_comb begin
      nxt_st      = st_ff;
      nxt_st.meta = pin_i;
      nxt_st.sync = st_ff.meta;
      nxt_st.last = st_ff.sync;
      // any change of level counts, only on enabled pins
      nxt_st.irq  = (st_ff.sync ^ st_ff.last) & irq_en_i;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign pin_sync_o = st_ff.sync;
   assign irq_o      = st_ff.irq;

   property p_irq_masked;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (irq_o != '0) |-> ((irq_o & ~$past(irq_en_i)) == '0);
   endproperty
   a_irq_masked: assert property (p_irq_masked)
      else $error("interrupt raised on a disabled pin");
endmodule : ext_irq_detect

// file: dv/cpu_core_model.sv
// behavioural cpu core that issues program, redirect and data requests
// assumes the bench calls its tasks; requests change at the falling edge
`timescale 1ns/100ps
module cpu_core_model
   import mmap_pkg::*;
(
   // clock and reset
   input  wire logic             clk_sys_i,
   input  wire logic             reset_n_i,
   // requests to the decoder
   output logic                  prog_req_o,
   output logic [PROG_AW-1:0]    prog_addr_o,
   output logic                  scall_req_o,
   output logic [VEC_IDX_W-1:0]  scall_idx_o,
   output logic                  irq_ack_o,
   output logic [VEC_IDX_W-1:0]  irq_src_o,
   output data_req_t             data_req_o
);
   // counts hold-offs that ran out with reset still low
   int stall_cnt = 0;

   initial begin
      prog_req_o  = 1'b0;
      prog_addr_o = '0;
      scall_req_o = 1'b0;
      scall_idx_o = '0;
      irq_ack_o   = 1'b0;
      irq_src_o   = '0;
      data_req_o  = '0;
   end
   // no request while reset is low, bounded so a stuck reset cannot hang
   task automatic hold_off();
      for (int i = 0; i < 8 && reset_n_i !== 1'b1; i++) @(negedge clk_sys_i);
      if (reset_n_i !== 1'b1) stall_cnt++;
      @(negedge clk_sys_i);
   endtask : hold_off
   // request lines drop and address and bank lines flip so a stale value never looks like a live request
   task automatic idle();
      @(negedge clk_sys_i);
      prog_req_o      = 1'b0;
      scall_req_o     = 1'b0;
      irq_ack_o       = 1'b0;
      data_req_o.req  = 1'b0;
      prog_addr_o     = ~prog_addr_o;
      data_req_o.addr = ~data_req_o.addr;
      data_req_o.bank = ~data_req_o.bank;
   endtask : idle
   task automatic fetch(input logic [PROG_AW-1:0] a);
      hold_off();
      prog_req_o  = 1'b1;
      prog_addr_o = a;
      idle();
   endtask : fetch
   task automatic redirect(input logic s, input logic [VEC_IDX_W-1:0] si,
                           input logic q, input logic [VEC_IDX_W-1:0] qs);
      hold_off();
      scall_req_o = s;
      scall_idx_o = si;
      irq_ack_o   = q;
      irq_src_o   = qs;
      idle();
   endtask : redirect
   task automatic daccess(input logic [BANK_W-1:0] b, input logic [DATA_AW-1:0] a);
      hold_off();
      data_req_o = '{req: 1'b1, bank: b, addr: a};
      idle();
   endtask : daccess
endmodule : cpu_core_model

// file: dv/tb_mcu_memory_map_decoder.sv
// self-checking bench for the program and data space decoder
// assumes the core model drives the core side; bench drives pins and peripherals
`timescale 1ns/100ps
module tb_mcu_memory_map_decoder
   import mmap_pkg::*;
;
   logic                  clk_sys_i;
   logic                  reset_n_i;
   logic                  prog_req, scall_req, irq_ack;
   logic [PROG_AW-1:0]    prog_addr;
   logic [VEC_IDX_W-1:0]  scall_idx, irq_src;
   data_req_t             data_req;
   logic [PORT_W-1:0]     input_port, irq_en, port_data, port_dir, sec_en, ext_drv, pin_lvl;
   sec_out_t              sec;
   logic                  pc_load_o, prog_sel_o, prog_err_o, prog_scall_o, prog_ivec_o;
   logic [PROG_AW-1:0]    pc_target_o;
   data_sel_t             data_sel_o;
   logic                  data_none_o, stack_sel_o, serial_rx_pin_o, sclk_in_o;
   logic [PORT_W-1:0]     ext_irq_o, output_port_o, output_port_oe_o;
   logic                  lg_prog_sel, lg_prog_err, lg_scall, lg_ivec, lg_none, lg_stack;
   data_sel_t             lg_data_sel;
   int                    error_cnt = 0;
   int                    checks_done = 0;

   // pin level: the decoder wins where it drives, the outside elsewhere
   assign pin_lvl = (output_port_oe_o & output_port_o) | (~output_port_oe_o & ext_drv);

   cpu_core_model core (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .prog_req_o(prog_req),
      .prog_addr_o(prog_addr), .scall_req_o(scall_req), .scall_idx_o(scall_idx),
      .irq_ack_o(irq_ack), .irq_src_o(irq_src), .data_req_o(data_req));

   mcu_memory_map_decoder #(.LARGE(1'b0)) dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .prog_req_i(prog_req), .prog_addr_i(prog_addr), .scall_req_i(scall_req),
      .scall_idx_i(scall_idx), .irq_ack_i(irq_ack), .irq_src_i(irq_src),
      .data_req_i(data_req), .input_port_i(input_port), .irq_en_i(irq_en),
      .port_data_i(port_data), .port_dir_i(port_dir), .sec_en_i(sec_en), .sec_i(sec),
      .output_port_pin_i(pin_lvl), .pc_load_o(pc_load_o), .pc_target_o(pc_target_o),
      .prog_sel_o(prog_sel_o), .prog_err_o(prog_err_o), .prog_scall_o(prog_scall_o),
      .prog_ivec_o(prog_ivec_o), .data_sel_o(data_sel_o), .data_none_o(data_none_o),
      .stack_sel_o(stack_sel_o), .ext_irq_o(ext_irq_o), .output_port_o(output_port_o),
      .output_port_oe_o(output_port_oe_o), .serial_rx_pin_o(serial_rx_pin_o),
      .sclk_in_o(sclk_in_o));

   // large variant shares the stimulus; only its decode outputs are judged
   mcu_memory_map_decoder #(.LARGE(1'b1)) dut_large (.clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i), .prog_req_i(prog_req), .prog_addr_i(prog_addr),
      .scall_req_i(scall_req), .scall_idx_i(scall_idx), .irq_ack_i(irq_ack),
      .irq_src_i(irq_src), .data_req_i(data_req), .input_port_i(input_port),
      .irq_en_i(irq_en), .port_data_i(port_data), .port_dir_i(port_dir), .sec_en_i(sec_en),
      .sec_i(sec), .output_port_pin_i(pin_lvl), .pc_load_o(), .pc_target_o(),
      .prog_sel_o(lg_prog_sel), .prog_err_o(lg_prog_err), .prog_scall_o(lg_scall),
      .prog_ivec_o(lg_ivec), .data_sel_o(lg_data_sel), .data_none_o(lg_none),
      .stack_sel_o(lg_stack), .ext_irq_o(), .output_port_o(), .output_port_oe_o(),
      .serial_rx_pin_o(), .sclk_in_o());

   initial begin
      clk_sys_i = 1'b0;
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      check("core_hold_off", 16'(core.stall_cnt), 16'h0000);
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : end_of_test

   task automatic t_reset();
      @(negedge clk_sys_i);
      reset_n_i = 1'b0;
      #1 check("reset_clear", 16'({pc_load_o, prog_sel_o, data_none_o, ext_irq_o,
               output_port_oe_o}), 16'h0000);
      repeat (3) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      @(negedge clk_sys_i);
      check("boot_pc", 16'({pc_load_o, pc_target_o}),
            16'({1'b1, RESET_ENTRY}));
      @(negedge clk_sys_i);
      check("boot_pulse", 16'(pc_load_o), 16'h0000);
      $display("test reset done");
   endtask : t_reset

   task automatic t_prog();
      logic [11:0] a [9] = '{12'h000, 12'h7ff, 12'h800, 12'hfff, 12'h010, 12'h01f,
                             12'h020, 12'h02f, 12'h030};
      logic [3:0]  e [9] = '{4'h8, 4'h8, 4'h4, 4'h4, 4'ha, 4'ha, 4'h9, 4'h9, 4'h8};
      logic [3:0]  el [9] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'ha, 4'ha, 4'h9, 4'h9, 4'h8};
      for (int i = 0; i < 9; i++) begin
         core.fetch(a[i]);
         check("prog_decode", 16'({prog_sel_o, prog_err_o, prog_scall_o, prog_ivec_o}),
               16'(e[i]));
         check("prog_decode_large", 16'({lg_prog_sel, lg_prog_err, lg_scall, lg_ivec}),
               16'(el[i]));
      end
      $display("test program decode done");
   endtask : t_prog

   task automatic t_data();
      logic [10:0] a [10] = '{11'h000, 11'h07f, 11'h080, 11'h0bf, 11'h0c0, 11'h7bf,
                              11'h7c0, 11'h7ff, 11'h1c0, 11'h3ff};
      logic [5:0]  e [10] = '{6'h10, 6'h10, 6'h08, 6'h08, 6'h02, 6'h02, 6'h05, 6'h05,
                              6'h02, 6'h02};
      logic [5:0]  el [10] = '{6'h10, 6'h10, 6'h08, 6'h08, 6'h08, 6'h05, 6'h05, 6'h05,
                               6'h02, 6'h02};
      for (int i = 0; i < 10; i++) begin
         core.daccess(a[i][10:8], a[i][7:0]);
         check("data_decode", 16'({prog_sel_o, data_sel_o, data_none_o, stack_sel_o}),
               16'(e[i]));
         check("data_decode_large", 16'({lg_prog_sel, lg_data_sel, lg_none, lg_stack}),
               16'(el[i]));
      end
      $display("test data decode done");
   endtask : t_data

   task automatic t_redirect();
      for (int i = 0; i < 16; i++) begin
         core.redirect(i < 8, 3'(i), i >= 8, 3'(i));
         check("vector_pc", 16'({pc_load_o, pc_target_o}), 16'({1'b1, (i < 8 ? SCALL_FIRST :
               IVEC_FIRST) + 12'(2 * (i % 8))}));
      end
      core.redirect(1'b1, 3'h5, 1'b1, 3'h2);
      check("irq_over_scall", 16'({pc_load_o, pc_target_o}),
            16'({1'b1, IVEC_FIRST + 12'h004}));
      @(negedge clk_sys_i);
      check("pc_pulse", 16'(pc_load_o), 16'h0000);
      $display("test redirect done");
   endtask : t_redirect

   task automatic t_irq();
      int cnt [4];
      for (int p = 0; p < 2; p++) begin
         irq_en = p ? 4'ha : 4'h5;
         foreach (cnt[k]) cnt[k] = 0;
         // both a rise and a fall, each must give one single-cycle pulse
         for (int s = 0; s < 2; s++) begin
            @(negedge clk_sys_i);
            input_port = ~input_port;
            repeat (8) begin
               @(negedge clk_sys_i);
               foreach (cnt[k]) cnt[k] += (ext_irq_o[k] === 1'b1) ? 1 : 0;
            end
         end
         foreach (cnt[k]) check("ext_irq_count", 16'(cnt[k]),
                                16'(2 * irq_en[k]));
      end
      $display("test pin interrupts done");
   endtask : t_irq

   task automatic port_try(input logic [3:0] en, input sec_out_t s, input logic [3:0] d,
                           input logic [3:0] x, input logic [9:0] e);
      sec_en    = en;
      sec       = s;
      port_data = d;
      ext_drv   = x;
      // synchronised pin levels need a few edges before they settle
      repeat (4) @(negedge clk_sys_i);
      check("port_mux", 16'({output_port_o & output_port_oe_o, output_port_oe_o,
            serial_rx_pin_o, sclk_in_o}), 16'(e));
   endtask : port_try

   task automatic t_port();
      port_dir = 4'hf;
      port_try(4'h0, 4'b0000, 4'ha, 4'h0, 10'h2bf);
      port_try(4'hf, 4'b1110, 4'h0, 4'ha, 10'h157);
      port_try(4'hf, 4'b0001, 4'h0, 4'h5, 10'h034);
      $display("test port mux done");
   endtask : t_port

   initial begin
      reset_n_i  = 1'b0;
      input_port = '0;
      irq_en     = '0;
      port_data  = '0;
      port_dir   = '0;
      sec_en     = '0;
      sec        = '0;
      ext_drv    = '0;
      t_reset();
      t_prog();
      t_data();
      t_redirect();
      t_irq();
      t_port();
      t_reset();
      end_of_test();
   end

   initial begin
      #1000000;
      error_cnt++;
      end_of_test();
   end
endmodule : tb_mcu_memory_map_decoder
